// >>> core/ibc_regs.vh
`ifndef IBC_REGS_VH
`define IBC_REGS_VH

// system clock period
`define IBC_CLK_PERIOD_NS 25

// data hold after a falling clock edge, long and short settings
`define IBC_HOLD_LONG_NS 300
`define IBC_HOLD_SHORT_NS 50
`define IBC_HOLD_LONG_CYC ((`IBC_HOLD_LONG_NS + `IBC_CLK_PERIOD_NS - 1) / `IBC_CLK_PERIOD_NS)
`define IBC_HOLD_SHORT_CYC ((`IBC_HOLD_SHORT_NS + `IBC_CLK_PERIOD_NS - 1) / `IBC_CLK_PERIOD_NS)

// master half bit period
`define IBC_MST_HALF_NS 1250
`define IBC_MST_HALF_CYC (`IBC_MST_HALF_NS / `IBC_CLK_PERIOD_NS)

// top five bits of a 10-bit high address byte
`define IBC_ADDR10_HI 5'h1E

// bit counter marks within a 9-bit segment
`define IBC_BIT_ACK 4'h8
`define IBC_BIT_END 4'h9

`endif

// >>> core/ibc_bus_logic.v
// Behaviour
// - addressed slave holds clock low after a bit until ready to go on
// - master raising clock waits while the line stays low
// - masters track start and stop, no new message while bus busy
// - transmitter comparing data line to its drive loses on first mismatch
// - losing master also releases clock, winner continues untouched
// - lower address wins at address stage, equal addresses arbitrate on
// - transfers are bytes msb first plus one acknowledge bit
// - after eighth falling edge transmitter releases data and samples acknowledge
// - data changes only with clock low, sampled on clock rise
// - enabled i2c mode forces open drain pins, data output tied zero
// - hold select stretches data hold to 300 ns after clock falls
// - flag collision when data samples low while driving or expecting high
// - start is data falling with clock high, bus goes active
// - collision on own start if data already low before pulling it
// - stop needs one clock low period first, else only start seen
// - bus idle when uncontrolled with both lines high, else active; bus_busy here is set only by start and cleared by stop
// - restart resets slave logic like start, ready for address byte
// - 10-bit read needs restart after full match, slave stretches then sends
// - prior match flag held until stop, high write or failed high match
// - slave sends bytes after read request until a byte is not acknowledged, restart or stop
// - 10-bit first byte compared with 11110, two top bits, zero
// - first byte after start compared with address, mismatch goes idle silently
// - 7-bit match ignores least significant bit of received byte
`timescale 1ns/1ps
`include "ibc_regs.vh"
module ibc_bus_logic #(
  parameter [11:0] HALF_CYC = `IBC_MST_HALF_CYC
) (
  input wire sys_clk,
  input wire rst_b,
  input wire port_enable_bit,
  input wire i2c_mode_sel,
  input wire data_hold_select,
  input wire addr_10bit_mode,
  input wire [9:0] slave_address_reg,
  input wire collision_clr,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_b,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_b,
  output reg pins_open_drain,
  output reg bus_busy,
  output reg start_seen,
  output reg stop_seen,
  output reg bus_collision,
  output reg prior_match,
  output reg slave_addressed,
  output reg slave_read,
  output reg [7:0] rx_data,
  output reg rx_valid,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output reg tx_taken,
  input wire mst_go,
  input wire [7:0] mst_data,
  input wire mst_stop,
  output reg mst_busy,
  output reg mst_done,
  output reg mst_nack,
  output reg arb_lost
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ADDR_LO = 3'h2;
  localparam [2:0] ST_RX = 3'h3;
  localparam [2:0] ST_TX = 3'h4;

  localparam [2:0] M_IDLE = 3'h0;
  localparam [2:0] M_START = 3'h1;
  localparam [2:0] M_LOW = 3'h2;
  localparam [2:0] M_HIGH = 3'h3;
  localparam [2:0] M_STOP1 = 3'h4;
  localparam [2:0] M_STOP2 = 3'h5;

  localparam integer HOLD_LONG_I = `IBC_HOLD_LONG_CYC;
  localparam integer HOLD_SHORT_I = `IBC_HOLD_SHORT_CYC;
  localparam [7:0] HOLD_LONG = HOLD_LONG_I[7:0];
  localparam [7:0] HOLD_SHORT = HOLD_SHORT_I[7:0];

  function hi_hit;
    input [7:0] b;
    input [9:0] a;
    begin
      hi_hit = (b[7:1] == {`IBC_ADDR10_HI, a[9:8]});
    end
  endfunction

  wire en = port_enable_bit & i2c_mode_sel;

  reg [1:0] scl_sy_q;
  reg [1:0] sda_sy_q;
  reg scl_prev_q;
  reg sda_prev_q;
  reg low_seen_q;
  reg [7:0] hold_cnt_q;

  reg [2:0] s_state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] rx_sh_q;
  reg [7:0] tx_sh_q;
  reg s_low_q;
  reg s_pend_q;
  reg s_nxt_q;
  reg ack_ok_q;
  reg need_load_q;
  reg rx_hold_q;
  reg s_coll_q;
  reg s_hold_q;

  reg [2:0] m_state_q;
  reg [11:0] m_timer_q;
  reg [3:0] m_bit_q;
  reg [7:0] m_sh_q;
  reg m_scl_low_q;
  reg m_sda_low_q;
  reg m_pend_q;
  reg m_nxt_q;
  reg m_pull_q;
  reg m_seen_hi_q;
  reg m_stop_q;
  reg own_q;
  reg go_pend_q;
  reg m_coll_q;

  // first stage feeds only the second
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_in};
      sda_sy_q <= {sda_sy_q[0], sda_in};
      scl_prev_q <= scl_sy_q[1];
      sda_prev_q <= sda_sy_q[1];
    end
  end

  wire scl_s = scl_sy_q[1];
  wire sda_s = sda_sy_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_det = en & scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det = en & scl_s & scl_prev_q & ~sda_prev_q & sda_s & low_seen_q;

  // bus state follows conditions only while enabled; idle needs a stop with both lines high
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_seen_q <= 1'b0;
      bus_busy <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      start_seen <= start_det;
      stop_seen <= stop_det;
      if (start_det || stop_det) begin
        low_seen_q <= 1'b0;
      end else if (!scl_s) begin
        low_seen_q <= 1'b1;
      end
      if (!en || stop_det) begin
        bus_busy <= 1'b0;
      end else if (start_det) begin
        bus_busy <= 1'b1;
      end
    end
  end

  // shared hold timer, restarted by any clock fall including our own pull
  wire hold_reload = scl_fall | m_pull_q;
  wire hold_done = (hold_cnt_q == 8'h00) & ~hold_reload;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_q <= 8'h00;
    end else if (hold_reload) begin
      hold_cnt_q <= data_hold_select ? HOLD_LONG : HOLD_SHORT;
    end else if (hold_cnt_q != 8'h00) begin
      hold_cnt_q <= hold_cnt_q - 8'h01;
    end
  end

  // slave side
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      s_low_q <= 1'b0;
      s_pend_q <= 1'b0;
      s_nxt_q <= 1'b0;
      ack_ok_q <= 1'b0;
      need_load_q <= 1'b0;
      rx_hold_q <= 1'b0;
      s_coll_q <= 1'b0;
      s_hold_q <= 1'b0;
      prior_match <= 1'b0;
      slave_read <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
      s_coll_q <= 1'b0;
      s_hold_q <= s_pend_q;
      if (s_pend_q && hold_done) begin
        s_low_q <= s_nxt_q;
        s_pend_q <= 1'b0;
      end
      if (!en || stop_det) begin
        s_state_q <= ST_IDLE;
        s_low_q <= 1'b0;
        s_pend_q <= 1'b0;
        need_load_q <= 1'b0;
        rx_hold_q <= 1'b0;
        prior_match <= 1'b0;
      end else if (start_det) begin
        s_state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        s_low_q <= 1'b0;
        s_pend_q <= 1'b0;
        need_load_q <= 1'b0;
        rx_hold_q <= 1'b0;
      end else begin
        if (rx_hold_q && rx_ready) begin
          rx_hold_q <= 1'b0;
        end
        if (need_load_q && tx_valid) begin
          need_load_q <= 1'b0;
          tx_taken <= 1'b1;
          s_nxt_q <= ~tx_data[7];
          s_pend_q <= 1'b1;
          tx_sh_q <= {tx_data[6:0], 1'b0};
        end
        if (scl_rise && s_state_q != ST_IDLE) begin
          if (bit_cnt_q < `IBC_BIT_ACK) begin
            rx_sh_q <= {rx_sh_q[6:0], sda_s};
          end
          if (bit_cnt_q == `IBC_BIT_ACK) begin
            ack_ok_q <= ~sda_s;
          end
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q < `IBC_BIT_ACK && s_state_q == ST_TX && !s_low_q && !sda_s) begin
            s_coll_q <= 1'b1;
            s_state_q <= ST_IDLE;
            s_low_q <= 1'b0;
            s_pend_q <= 1'b0;
          end
        end
        if (scl_fall && s_state_q != ST_IDLE) begin
          if (bit_cnt_q == `IBC_BIT_ACK) begin
            s_pend_q <= 1'b1;
            s_nxt_q <= 1'b1;
            case (s_state_q)
              ST_ADDR: begin
                if (addr_10bit_mode) begin
                  if (hi_hit(rx_sh_q, slave_address_reg) && !rx_sh_q[0]) begin
                    s_state_q <= ST_ADDR_LO;
                    prior_match <= 1'b0;
                  end else if (hi_hit(rx_sh_q, slave_address_reg) && prior_match) begin
                    s_state_q <= ST_TX;
                    slave_read <= 1'b1;
                  end else begin
                    s_state_q <= ST_IDLE;
                    s_pend_q <= 1'b0;
                    prior_match <= 1'b0;
                  end
                end else if (rx_sh_q[7:1] == slave_address_reg[6:0]) begin
                  slave_read <= rx_sh_q[0];
                  s_state_q <= rx_sh_q[0] ? ST_TX : ST_RX;
                end else begin
                  s_state_q <= ST_IDLE;
                  s_pend_q <= 1'b0;
                end
              end
              ST_ADDR_LO: begin
                if (rx_sh_q == slave_address_reg[7:0]) begin
                  s_state_q <= ST_RX;
                  slave_read <= 1'b0;
                  prior_match <= 1'b1;
                end else begin
                  s_state_q <= ST_IDLE;
                  s_pend_q <= 1'b0;
                end
              end
              ST_RX: begin
                rx_data <= rx_sh_q;
                rx_valid <= 1'b1;
              end
              ST_TX: begin
                s_nxt_q <= 1'b0;
              end
              default: begin
                s_state_q <= ST_IDLE;
              end
            endcase
          end else if (bit_cnt_q == `IBC_BIT_END) begin
            bit_cnt_q <= 4'h0;
            s_nxt_q <= 1'b0;
            s_pend_q <= 1'b1;
            if (s_state_q == ST_TX) begin
              if (ack_ok_q) begin
                need_load_q <= 1'b1;
              end else begin
                s_state_q <= ST_IDLE;
              end
            end else if (s_state_q == ST_RX && !rx_ready) begin
              rx_hold_q <= 1'b1;
            end
          end else if (s_state_q == ST_TX && bit_cnt_q != 4'h0) begin
            s_nxt_q <= ~tx_sh_q[7];
            s_pend_q <= 1'b1;
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // master side; the clock edge we make is also seen back through the pin
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_state_q <= M_IDLE;
      m_timer_q <= 12'h000;
      m_bit_q <= 4'h0;
      m_sh_q <= 8'h00;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
      m_pend_q <= 1'b0;
      m_nxt_q <= 1'b0;
      m_pull_q <= 1'b0;
      m_seen_hi_q <= 1'b0;
      m_stop_q <= 1'b0;
      own_q <= 1'b0;
      go_pend_q <= 1'b0;
      m_coll_q <= 1'b0;
      mst_done <= 1'b0;
      mst_nack <= 1'b0;
      arb_lost <= 1'b0;
    end else begin
      mst_done <= 1'b0;
      m_pull_q <= 1'b0;
      m_coll_q <= 1'b0;
      arb_lost <= 1'b0;
      if (m_pend_q && hold_done) begin
        m_sda_low_q <= m_nxt_q;
        m_pend_q <= 1'b0;
      end
      if (m_timer_q != 12'h000) begin
        m_timer_q <= m_timer_q - 12'h001;
      end
      if (!en) begin
        m_state_q <= M_IDLE;
        m_scl_low_q <= 1'b0;
        m_sda_low_q <= 1'b0;
        m_pend_q <= 1'b0;
        own_q <= 1'b0;
        go_pend_q <= 1'b0;
      end else begin
        case (m_state_q)
          M_IDLE: begin
            if (mst_go && !go_pend_q) begin
              go_pend_q <= 1'b1;
              m_sh_q <= mst_data;
              m_stop_q <= mst_stop;
            end
            if (go_pend_q) begin
              if (own_q) begin
                go_pend_q <= 1'b0;
                m_bit_q <= 4'h0;
                m_nxt_q <= ~m_sh_q[7];
                m_pend_q <= 1'b1;
                m_pull_q <= 1'b1;
                m_timer_q <= HALF_CYC;
                m_state_q <= M_LOW;
              end else if (!bus_busy && scl_s && sda_s) begin
                go_pend_q <= 1'b0;
                m_sda_low_q <= 1'b1;
                own_q <= 1'b1;
                m_timer_q <= HALF_CYC;
                m_state_q <= M_START;
              end else if (!bus_busy && scl_s && !sda_s) begin
                go_pend_q <= 1'b0;
                m_coll_q <= 1'b1;
                arb_lost <= 1'b1;
              end
            end
          end
          M_START: begin
            if (m_timer_q == 12'h000) begin
              m_scl_low_q <= 1'b1;
              m_pull_q <= 1'b1;
              m_bit_q <= 4'h0;
              m_nxt_q <= ~m_sh_q[7];
              m_pend_q <= 1'b1;
              m_timer_q <= HALF_CYC;
              m_state_q <= M_LOW;
            end
          end
          M_LOW: begin
            if (m_timer_q == 12'h000 && !m_pend_q) begin
              m_scl_low_q <= 1'b0;
              m_seen_hi_q <= 1'b0;
              m_state_q <= M_HIGH;
            end
          end
          M_HIGH: begin
            if (!m_seen_hi_q) begin
              if (scl_s) begin
                m_seen_hi_q <= 1'b1;
                m_timer_q <= HALF_CYC;
                if (m_bit_q < `IBC_BIT_ACK && !m_sda_low_q && !sda_s) begin
                  m_scl_low_q <= 1'b0;
                  m_sda_low_q <= 1'b0;
                  m_pend_q <= 1'b0;
                  own_q <= 1'b0;
                  arb_lost <= 1'b1;
                  m_coll_q <= 1'b1;
                  m_state_q <= M_IDLE;
                end else if (m_bit_q == `IBC_BIT_ACK) begin
                  mst_nack <= sda_s;
                end
              end
            end else if (m_timer_q == 12'h000) begin
              m_scl_low_q <= 1'b1;
              m_pull_q <= 1'b1;
              if (m_bit_q == `IBC_BIT_ACK) begin
                mst_done <= 1'b1;
                if (m_stop_q) begin
                  m_nxt_q <= 1'b1;
                  m_pend_q <= 1'b1;
                  m_timer_q <= HALF_CYC;
                  m_state_q <= M_STOP1;
                end else begin
                  m_state_q <= M_IDLE;
                end
              end else begin
                m_bit_q <= m_bit_q + 4'h1;
                m_nxt_q <= (m_bit_q == 4'h7) ? 1'b0 : ~m_sh_q[6];
                m_sh_q <= {m_sh_q[6:0], 1'b0};
                m_pend_q <= 1'b1;
                m_timer_q <= HALF_CYC;
                m_state_q <= M_LOW;
              end
            end
          end
          M_STOP1: begin
            if (m_timer_q == 12'h000 && !m_pend_q) begin
              m_scl_low_q <= 1'b0;
              m_seen_hi_q <= 1'b0;
              m_state_q <= M_STOP2;
            end
          end
          M_STOP2: begin
            if (!m_seen_hi_q) begin
              if (scl_s) begin
                m_seen_hi_q <= 1'b1;
                m_timer_q <= HALF_CYC;
              end
            end else if (m_timer_q == 12'h000) begin
              m_sda_low_q <= 1'b0;
              own_q <= 1'b0;
              m_state_q <= M_IDLE;
            end
          end
          default: begin
            m_state_q <= M_IDLE;
          end
        endcase
      end
    end
  end

  // slave keeps clock low until its new bit is on the pin, else a false start
  wire s_stretch = rx_hold_q | need_load_q | s_pend_q | s_hold_q;

  // pins and status; outputs all registered, set of collision beats clear
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_b <= 1'b1;
      sda_oe_b <= 1'b1;
      pins_open_drain <= 1'b0;
      bus_collision <= 1'b0;
      slave_addressed <= 1'b0;
      mst_busy <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      pins_open_drain <= en;
      scl_oe_b <= ~(en & (m_scl_low_q | s_stretch));
      sda_oe_b <= ~(en & (s_low_q | m_sda_low_q));
      if (s_coll_q || m_coll_q) begin
        bus_collision <= 1'b1;
      end else if (collision_clr) begin
        bus_collision <= 1'b0;
      end
      slave_addressed <= (s_state_q == ST_RX) || (s_state_q == ST_TX);
      mst_busy <= go_pend_q | (m_state_q != M_IDLE) | mst_go;
    end
  end

endmodule

// >>> verification/ibc_chk_assertions.sv
`timescale 1ns/1ps
module ibc_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic port_enable_bit,
  input wire logic i2c_mode_sel,
  input wire logic data_hold_select,
  input wire logic collision_clr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_b,
  input wire logic sda_out,
  input wire logic sda_oe_b,
  input wire logic pins_open_drain,
  input wire logic bus_busy,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic bus_collision,
  input wire logic mst_go,
  input wire logic mst_busy,
  input wire logic arb_lost
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_out_zero: assert property (!scl_out && !sda_out)
    else $error("pin data not zero");
  chk_od_follow: assert property (port_enable_bit && i2c_mode_sel |-> ##2 pins_open_drain)
    else $error("open drain not forced");
  chk_start_busy: assert property ($rose(start_seen) |-> ##[0:1] bus_busy)
    else $error("start left bus idle");
  chk_stop_idle: assert property (stop_seen |-> ##[0:1] !bus_busy)
    else $error("stop left bus busy");
  chk_coll_sticky: assert property (bus_collision && !collision_clr |=> bus_collision)
    else $error("collision flag dropped");
  chk_arb_coll: assert property (arb_lost |-> ##[0:1] bus_collision)
    else $error("loss without collision");
  chk_arb_release: assert property (arb_lost |-> ##[0:2] (sda_oe_b && scl_oe_b))
    else $error("lines kept after loss");
  chk_hold_long: assert property (data_hold_select && !mst_busy && !$past(mst_busy)
    && $changed(sda_oe_b) |-> !scl_in && $past(scl_in, 12) == 1'b0)
    else $error("long hold broken");
  chk_hold_short: assert property (!data_hold_select && !mst_busy && !$past(mst_busy)
    && $changed(sda_oe_b) |-> !scl_in && $past(scl_in, 4) == 1'b0)
    else $error("data moved near clock edge");
  chk_go_taken: assert property (mst_go && !mst_busy |=> mst_busy)
    else $error("request not taken");
endmodule

bind ibc_bus_logic ibc_chk u_chk (.sys_clk, .rst_b, .port_enable_bit, .i2c_mode_sel,
  .data_hold_select, .collision_clr, .scl_in, .scl_out, .scl_oe_b, .sda_out, .sda_oe_b,
  .pins_open_drain, .bus_busy, .start_seen, .stop_seen, .bus_collision, .mst_go,
  .mst_busy, .arb_lost);

// >>> verification/ibc_partner.sv
`timescale 1ns/1ps
module ibc_partner (
  input wire logic scl,
  input wire logic sda,
  input wire logic slave_en,
  output logic scl_oe_b,
  output logic sda_oe_b
);
  logic [7:0] s_byte = 8'h00;
  logic [7:0] s_sh = 8'h00;
  int s_n = 0;
  int k;
  initial begin
    scl_oe_b = 1;
    sda_oe_b = 1;
  end
  task m_start;
    sda_oe_b = 0; // data falls with clock high
    #200;
    scl_oe_b = 0;
    #200;
  endtask
  task m_bit(input logic b, output logic r);
    #100;
    sda_oe_b = b; // data moves only with clock low
    #500;
    scl_oe_b = 1;
    for (k = 0; k < 400 && scl !== 1'b1; k++) #25; // stretched clock waits
    #100;
    r = sda;
    #100;
    scl_oe_b = 0;
  endtask
  task m_byte(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      m_bit(d[i], r); // msb first
      q[i] = r;
    end
    m_bit(ai, ao); // ninth bit is the acknowledge
  endtask
  task m_stop;
    scl_oe_b = 0;
    #100;
    sda_oe_b = 0;
    #500; // clock low long enough for a long data hold to finish
    scl_oe_b = 1;
    #200;
    sda_oe_b = 1; // rise after a clock low period
    #300;
  endtask
  task m_glitch;
    sda_oe_b = 0; // clock never low, so only a start
    #300;
    sda_oe_b = 1;
    #300;
  endtask
  task m_sda_low;
    scl_oe_b = 0;
    #100;
    sda_oe_b = 0;
    #100;
    scl_oe_b = 1;
    #300;
  endtask
  task m_release;
    sda_oe_b = 1;
    #300;
  endtask
  always @(posedge scl) if (slave_en) begin
    s_n++;
    if (s_n <= 8) s_sh = {s_sh[6:0], sda}; // sampled on rising clock
  end
  always @(negedge sda) if (scl === 1'b1) s_n = 0; // start restarts the count
  always @(negedge scl) if (slave_en) begin
    if (s_n == 8) begin
      s_byte = s_sh;
      #60; // off the system clock edge
      sda_oe_b = 0;
      scl_oe_b = 0; // slow slave holds clock
      #1000;
      scl_oe_b = 1;
    end else if (s_n == 9) begin
      #60;
      sda_oe_b = 1;
      s_n = 0;
    end
  end
endmodule

// >>> verification/i2c_bus_condition_logic_tb.sv
`timescale 1ns/1ps
module i2c_bus_condition_logic_tb;
  logic sys_clk = 0, rst_b = 0, port_enable_bit = 0, i2c_mode_sel = 1, data_hold_select = 0;
  logic addr_10bit_mode = 0, collision_clr = 0, rx_ready = 1, tx_valid = 0, mst_go = 0;
  logic mst_stop = 0, p_slave_en = 0;
  logic [9:0] slave_address_reg = 10'h05A;
  logic [7:0] tx_data = 8'h00, mst_data = 8'h00, rx_data, q, rx_last = 8'h00;
  logic scl_in, sda_in, scl_out, scl_oe_b, sda_out, sda_oe_b, pins_open_drain, bus_busy;
  logic start_seen, stop_seen, bus_collision, prior_match, slave_addressed, slave_read;
  logic rx_valid, tx_taken, mst_busy, mst_done, mst_nack, arb_lost, p_scl_oe_b, p_sda_oe_b, a;
  int fail_count = 0, tests_run = 0, n_start = 0, n_stop = 0, cyc = 0, k;
  assign scl_in = scl_oe_b & p_scl_oe_b; // pull-up wins when nobody pulls
  assign sda_in = sda_oe_b & p_sda_oe_b;
  always #12.5 sys_clk = ~sys_clk;
  ibc_bus_logic #(.HALF_CYC(12'd20)) dut (.sys_clk, .rst_b, .port_enable_bit, .i2c_mode_sel,
    .data_hold_select, .addr_10bit_mode, .slave_address_reg, .collision_clr, .scl_in,
    .scl_out, .scl_oe_b, .sda_in, .sda_out, .sda_oe_b, .pins_open_drain, .bus_busy,
    .start_seen, .stop_seen, .bus_collision, .prior_match, .slave_addressed, .slave_read,
    .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_taken, .mst_go, .mst_data,
    .mst_stop, .mst_busy, .mst_done, .mst_nack, .arb_lost);
  ibc_partner p (.scl(scl_in), .sda(sda_in), .slave_en(p_slave_en), .scl_oe_b(p_scl_oe_b),
    .sda_oe_b(p_sda_oe_b));
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (start_seen === 1'b1) n_start <= n_start + 1;
    if (stop_seen === 1'b1) n_stop <= n_stop + 1;
    if (rx_valid === 1'b1) rx_last <= rx_data;
    if (cyc == 20000) begin
      fail_count++; // hang cut short
      close_out;
    end
  end
  task tick;
    @(posedge sys_clk);
    #2;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task t_write7(input logic h);
    data_hold_select = h;
    p.m_start;
    chk(bus_busy, 1'b1);
    p.m_byte(8'hB4, 1'b1, q, a);
    chk({a, slave_addressed}, 2'b01);
    p.m_byte(8'hA5, 1'b1, q, a);
    chk({a, rx_last}, 9'h0A5);
    p.m_stop;
    chk({bus_busy, slave_addressed}, 2'b00);
    $display("test write done");
  endtask
  task t_badaddr;
    p.m_start;
    p.m_byte(8'hB6, 1'b1, q, a);
    chk({a, slave_addressed}, 2'b10);
    p.m_stop;
    $display("test bad address done");
  endtask
  task t_glitch;
    int s0, s1;
    s0 = n_start;
    s1 = n_stop;
    p.m_glitch;
    chk(16'(n_start - s0), 16'd1);
    chk({15'(n_stop - s1), bus_busy}, 16'd1);
    p.m_stop;
    chk({15'(n_stop - s1), bus_busy}, 16'd2);
    $display("test false stop done");
  endtask
  task t_read7;
    p.m_start;
    p.m_byte(8'hB5, 1'b1, q, a);
    chk({a, slave_read}, 2'b01);
    fork
      p.m_byte(8'hFF, 1'b1, q, a);
      begin
        repeat (40) tick;
        chk(scl_in, 1'b0);
        tx_data = 8'h3C;
        tx_valid = 1;
        for (k = 0; k < 50 && tx_taken !== 1'b1; k++) tick;
        tx_valid = 0;
        chk(tx_taken, 1'b1);
      end
    join
    chk(q, 8'h3C);
    p.m_stop;
    $display("test read done");
  endtask
  task send(input logic [7:0] d, input logic s);
    mst_data = d;
    mst_stop = s;
    mst_go = 1;
    tick;
    mst_go = 0;
    for (k = 0; k < 3000 && mst_done !== 1'b1; k++) tick;
  endtask
  task t_master;
    p_slave_en = 1;
    send(8'h96, 1'b0);
    chk({mst_done, mst_nack, p.s_byte}, 10'h296);
    tick;
    send(8'h3B, 1'b1);
    chk({mst_done, mst_nack, p.s_byte}, 10'h23B);
    for (k = 0; k < 500 && bus_busy !== 1'b0; k++) tick;
    chk({bus_busy, mst_busy}, 2'b00);
    p_slave_en = 0;
    $display("test master done");
  endtask
  task t_coll;
    p.m_sda_low;
    mst_data = 8'h55;
    mst_stop = 1;
    mst_go = 1;
    tick;
    mst_go = 0;
    for (k = 0; k < 40 && arb_lost !== 1'b1; k++) tick;
    chk(arb_lost, 1'b1);
    repeat (3) tick;
    chk({bus_collision, mst_busy, sda_oe_b}, 3'b101);
    p.m_release;
    collision_clr = 1;
    tick;
    collision_clr = 0;
    tick;
    chk(bus_collision, 1'b0);
    $display("test start collision done");
  endtask
  task t_ten;
    addr_10bit_mode = 1;
    slave_address_reg = 10'h2C7;
    tick;
    p.m_start;
    p.m_byte(8'hF4, 1'b1, q, a);
    chk(a, 1'b0);
    p.m_byte(8'hC7, 1'b1, q, a);
    chk({a, prior_match}, 2'b01);
    p.m_stop;
    chk(prior_match, 1'b0);
    addr_10bit_mode = 0;
    slave_address_reg = 10'h05A;
    $display("test ten bit done");
  endtask
  initial begin
    repeat (20) tick;
    chk({scl_oe_b, sda_oe_b, bus_busy, bus_collision, prior_match, slave_addressed}, 6'h30);
    rst_b = 1;
    port_enable_bit = 1;
    repeat (3) tick;
    chk({pins_open_drain, scl_out, sda_out}, 3'h4);
    $display("test reset done");
    t_write7(1'b1);
    t_write7(1'b0);
    t_badaddr;
    t_glitch;
    t_read7;
    t_master;
    t_coll;
    t_ten;
    close_out;
  end
endmodule
